// ---- src/hts_pkg.sv ----
// shared constants and types for the host-to-card stream ports
package hts_pkg;

    // ----------------------------------------------------------------
    // widths and rates
    // ----------------------------------------------------------------
    localparam int DATA_W      = 64;
    localparam int BYTES       = DATA_W / 8;
    localparam int CSR_W       = 32;
    localparam int ADDR_W      = 8;
    localparam int NCH         = 4;
    localparam int CH_W        = 2;
    localparam int LEN_W       = 16;
    localparam int CLK_MHZ     = 100;
    localparam int MAX_MHZ     = 250;
    localparam int RST_SYNC_N  = 2;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_DESC = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SEED = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_DONE = 8'h10;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_CH_EN_LSB = 0;
    localparam int CTRL_PAR_BIT   = 4;
    localparam int DESC_LEN_LSB   = 0;
    localparam int DESC_CH_LSB    = 16;
    localparam int DESC_EOP_BIT   = 18;
    localparam int STAT_LINK_BIT  = 0;
    localparam int STAT_MSI_BIT   = 1;
    localparam int STAT_MSIW_LSB  = 2;
    localparam int STAT_BUSY_BIT  = 5;
    localparam int STAT_VLD_LSB   = 8;
    localparam logic [4:0] CTRL_RST = 5'h0F;
    localparam logic [7:0] SEED_RST = 8'h00;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [BYTES-1:0]  keep;
        logic [BYTES-1:0]  user;
        logic              last;
    } hts_beat_s;

    typedef struct packed {
        logic [LEN_W-1:0] len;
        logic [CH_W-1:0]  ch;
        logic             eop;
    } hts_desc_s;

    typedef enum logic [0:0] {
        GEN_IDLE = 1'b0,
        GEN_RUN  = 1'b1
    } hts_gen_e;

endpackage

// ---- src/hts_skid2.sv ----
// two-entry stream buffer with valid/ready on both sides
`timescale 1ns/1ns
module hts_skid2 import hts_pkg::*; (
    input  wire logic      i_clk_sys,
    input  wire logic      i_reset,
    input  wire logic      i_clear,
    input  wire logic      i_in_valid,
    output logic           o_in_ready,
    input  wire hts_beat_s i_in_beat,
    output logic           o_out_valid,
    input  wire logic      i_out_ready,
    output hts_beat_s      o_out_beat
);
    hts_beat_s  mem_q [2];
    logic       wr_q;
    logic       rd_q;
    logic [1:0] cnt_q;
    wire        push = i_in_valid && o_in_ready;
    wire        pop  = o_out_valid && i_out_ready;

    assign o_in_ready  = (cnt_q != 2'h2);
    assign o_out_valid = (cnt_q != 2'h0);
    assign o_out_beat  = mem_q[rd_q];

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else if (i_clear) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            wr_q  <= wr_q ^ push;
            rd_q  <= rd_q ^ pop;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= i_in_beat;
        end
    end

    buf_count_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        cnt_q <= 2'h2) else $error("buffer count out of range");
endmodule

// ---- src/hts_beat_gen.sv ----
// forms stream beats for one descriptor at a time
`timescale 1ns/1ns
module hts_beat_gen import hts_pkg::*; (
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset,
    input  wire logic       i_clear,
    input  wire logic       i_start,
    input  wire hts_desc_s  i_desc,
    input  wire logic [7:0] i_seed,
    input  wire logic       i_parity_en,
    input  wire logic       i_ready,
    output logic            o_valid,
    output hts_beat_s       o_beat,
    output logic [CH_W-1:0] o_ch,
    output logic            o_busy,
    output logic            o_done
);
    hts_gen_e         state_q;
    logic [LEN_W-1:0] rem_q;
    logic [7:0]       cnt_q;
    logic             eop_q;
    logic [CH_W-1:0]  ch_q;
    wire              fire  = o_valid && i_ready;
    wire              final_beat = (rem_q <= LEN_W'(BYTES));

    assign o_valid = (state_q == GEN_RUN);
    assign o_busy  = (state_q == GEN_RUN);
    assign o_ch    = ch_q;
    assign o_done  = fire && final_beat;
    // packing stops at the descriptor end; the next one starts a fresh beat
    assign o_beat.last = final_beat && eop_q;

    for (genvar b = 0; b < BYTES; b++) begin : g_byte
        assign o_beat.data[8*b +: 8] = cnt_q + 8'(b);
        assign o_beat.keep[b] = (rem_q > LEN_W'(b));
        assign o_beat.user[b] = i_parity_en && ^(cnt_q + 8'(b));
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            state_q <= GEN_IDLE;
            rem_q   <= '0;
            cnt_q   <= 8'h00;
            eop_q   <= 1'b0;
            ch_q    <= '0;
        end else if (i_clear) begin
            state_q <= GEN_IDLE;
        end else begin
            case (state_q)
                GEN_IDLE: begin
                    if (i_start) begin
                        state_q <= GEN_RUN;
                        rem_q   <= i_desc.len;
                        cnt_q   <= i_seed;
                        eop_q   <= i_desc.eop;
                        ch_q    <= i_desc.ch;
                    end
                end
                GEN_RUN: begin
                    if (fire && final_beat) begin
                        state_q <= GEN_IDLE;
                    end else if (fire) begin
                        rem_q <= rem_q - LEN_W'(BYTES);
                        cnt_q <= cnt_q + 8'(BYTES);
                    end
                end
                default: state_q <= GEN_IDLE;
            endcase
        end
    end

    keep_full_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        o_valid && !final_beat |-> (o_beat.keep == {BYTES{1'b1}}))
        else $error("partial keep before final beat");
    last_eop_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        o_valid && o_beat.last |-> eop_q && final_beat)
        else $error("last without end of descriptor packet");
endmodule

// ---- src/hts_top.sv ----
// host-to-card stream ports with status outputs and register port
// ----------------------------------------------------------------
// Operation
// - datapath width is 64, 128, 256 or 512
// - control register port is 32 bits wide
// - datapath clock no faster than 250 MHz
// - user clock output derived from link clock
// - active-low user reset synchronous to user clock
// - link-up output high while core linked
// - msi enable output high when enabled
// - 3-bit output gives allocated msi vector count
// - four independent stream channels, zero to three; one shared beat generator feeds them, so a stalled channel blocks the rest
// - beat moves only when valid and ready
// - valid held while ready stays low
// - valid high whenever payload is valid
// - last marks final beat of packet
// - parity sideband only in parity mode
// - keep all ones except short final beat
// - never pack bytes across descriptors
// - last only on final beat with flag
// ----------------------------------------------------------------
`timescale 1ns/1ns
module hts_top import hts_pkg::*; (
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_reset,
    input  wire logic                          i_host_reset_n,
    input  wire logic                          i_core_link_up,
    input  wire logic                          i_core_msi_enable,
    input  wire logic [2:0]                    i_core_msi_width,
    input  wire logic [ADDR_W-1:0]             i_reg_addr,
    input  wire logic [CSR_W-1:0]              i_reg_wdata,
    input  wire logic                          i_reg_write,
    input  wire logic                          i_reg_read,
    output logic      [CSR_W-1:0]              o_reg_rdata,
    output logic                               o_user_clk,
    output logic                               o_user_reset_n,
    output logic                               o_link_up,
    output logic                               o_msi_enable,
    output logic      [2:0]                    o_msi_width,
    input  wire logic [NCH-1:0]                i_downstream_sink_ready,
    output logic      [NCH-1:0]                o_downstream_payload_valid,
    output logic      [NCH-1:0][DATA_W-1:0]    o_downstream_payload,
    output logic      [NCH-1:0][BYTES-1:0]     o_downstream_keep,
    output logic      [NCH-1:0]                o_downstream_packet_last,
    output logic      [NCH-1:0][BYTES-1:0]     o_downstream_parity_sideband
);
    // ----------------------------------------------------------------
    // clock and user reset
    // ----------------------------------------------------------------
    logic [RST_SYNC_N-1:0] rst_sync_q;
    logic                  user_rst;

    assign o_user_clk = i_clk_sys;

    // host reset is taken as synchronous; asserts in one edge, releases after two
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            rst_sync_q <= '0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], i_host_reset_n} & {RST_SYNC_N{i_host_reset_n}};
        end
    end

    assign o_user_reset_n = rst_sync_q[RST_SYNC_N-1];
    assign user_rst       = !o_user_reset_n;

    // ----------------------------------------------------------------
    // status from the link core
    // ----------------------------------------------------------------
    logic       link_q;
    logic       msi_en_q;
    logic [2:0] msi_w_q;

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            link_q   <= 1'b0;
            msi_en_q <= 1'b0;
            msi_w_q  <= 3'h0;
        end else begin
            link_q   <= i_core_link_up;
            msi_en_q <= i_core_msi_enable;
            msi_w_q  <= i_core_msi_width;
        end
    end

    assign o_link_up    = link_q;
    assign o_msi_enable = msi_en_q;
    assign o_msi_width  = msi_w_q;

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    logic [4:0]       ctrl_q;
    logic [7:0]       seed_q;
    logic [CSR_W-1:0] done_q;
    logic [CSR_W-1:0] rdata_q;
    logic             gen_busy;
    logic             gen_done;
    hts_desc_s        desc_in;

    wire              hit_ctrl = (i_reg_addr == OFS_CTRL);
    wire              hit_stat = (i_reg_addr == OFS_STAT);
    wire              hit_desc = (i_reg_addr == OFS_DESC);
    wire              hit_seed = (i_reg_addr == OFS_SEED);
    wire              hit_done = (i_reg_addr == OFS_DONE);
    wire [NCH-1:0]    ch_en    = ctrl_q[CTRL_CH_EN_LSB +: NCH];
    wire              par_en   = ctrl_q[CTRL_PAR_BIT];

    assign desc_in.len = i_reg_wdata[DESC_LEN_LSB +: LEN_W];
    assign desc_in.ch  = i_reg_wdata[DESC_CH_LSB +: CH_W];
    assign desc_in.eop = i_reg_wdata[DESC_EOP_BIT];

    // a descriptor written while busy, zero-length or before reset release is dropped
    wire desc_start = i_reg_write && hit_desc && !gen_busy && !user_rst
                      && (desc_in.len != '0);

    wire [CSR_W-1:0] stat_word =
        (CSR_W'(link_q) << STAT_LINK_BIT)
        | (CSR_W'(msi_en_q) << STAT_MSI_BIT)
        | (CSR_W'(msi_w_q) << STAT_MSIW_LSB)
        | (CSR_W'(gen_busy) << STAT_BUSY_BIT)
        | (CSR_W'(o_downstream_payload_valid) << STAT_VLD_LSB);

    // unmapped offsets read as zero; narrow registers sit in the low bits
    wire [CSR_W-1:0] rd_mux =
        hit_ctrl ? CSR_W'(ctrl_q) :
        hit_stat ? stat_word :
        hit_seed ? CSR_W'(seed_q) :
        hit_done ? done_q : '0;

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            ctrl_q <= CTRL_RST;
            seed_q <= SEED_RST;
        end else if (i_reg_write) begin
            ctrl_q <= hit_ctrl ? i_reg_wdata[4:0] : ctrl_q;
            seed_q <= hit_seed ? i_reg_wdata[7:0] : seed_q;
        end
    end

    // completed-descriptor count; a software write clears it, a completion in the same cycle leaves it at one
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            done_q <= '0;
        end else if (gen_done) begin
            done_q <= (i_reg_write && hit_done) ? CSR_W'(1) : done_q + CSR_W'(1);
        end else if (i_reg_write && hit_done) begin
            done_q <= '0;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= i_reg_read ? rd_mux : '0;
        end
    end

    assign o_reg_rdata = rdata_q;

    // ----------------------------------------------------------------
    // beat generator
    // ----------------------------------------------------------------
    logic            gen_valid;
    logic            gen_ready;
    hts_beat_s       gen_beat;
    logic [CH_W-1:0] gen_ch;
    logic [NCH-1:0]  buf_in_ready;

    // a disabled channel stalls the generator rather than dropping data
    assign gen_ready = buf_in_ready[gen_ch] && ch_en[gen_ch];

    hts_beat_gen u_gen (
        .i_clk_sys   (i_clk_sys),
        .i_reset     (i_reset),
        .i_clear     (user_rst),
        .i_start     (desc_start),
        .i_desc      (desc_in),
        .i_seed      (seed_q),
        .i_parity_en (par_en),
        .i_ready     (gen_ready),
        .o_valid     (gen_valid),
        .o_beat      (gen_beat),
        .o_ch        (gen_ch),
        .o_busy      (gen_busy),
        .o_done      (gen_done)
    );

    // ----------------------------------------------------------------
    // per-channel output buffers
    // ----------------------------------------------------------------
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        hts_beat_s out_beat;
        wire       in_valid = gen_valid && (gen_ch == CH_W'(c)) && ch_en[c];

        hts_skid2 u_buf (
            .i_clk_sys   (i_clk_sys),
            .i_reset     (i_reset),
            .i_clear     (user_rst),
            .i_in_valid  (in_valid),
            .o_in_ready  (buf_in_ready[c]),
            .i_in_beat   (gen_beat),
            .o_out_valid (o_downstream_payload_valid[c]),
            .i_out_ready (i_downstream_sink_ready[c]),
            .o_out_beat  (out_beat)
        );

        assign o_downstream_payload[c]         = out_beat.data;
        assign o_downstream_keep[c]            = out_beat.keep;
        assign o_downstream_packet_last[c]     = out_beat.last;
        assign o_downstream_parity_sideband[c] = out_beat.user;

        valid_hold_a: assert property (@(posedge i_clk_sys)
            disable iff (i_reset || user_rst)
            o_downstream_payload_valid[c] && !i_downstream_sink_ready[c]
            |=> o_downstream_payload_valid[c] && $stable(o_downstream_payload[c])
                && $stable(o_downstream_packet_last[c]))
            else $error("valid or payload changed while stalled");
        keep_packed_a: assert property (@(posedge i_clk_sys)
            disable iff (i_reset || user_rst)
            o_downstream_payload_valid[c]
            |-> ((o_downstream_keep[c] + BYTES'(1)) & o_downstream_keep[c]) == '0
                && o_downstream_keep[c] != '0)
            else $error("keep not packed to low bytes");
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    width_ok_a: assert property (@(posedge i_clk_sys)
        DATA_W == 64 || DATA_W == 128 || DATA_W == 256 || DATA_W == 512)
        else $error("unsupported datapath width");
    clk_rate_a: assert property (@(posedge i_clk_sys)
        CLK_MHZ <= MAX_MHZ) else $error("datapath clock too fast");
    user_reset_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !i_host_reset_n |=> !o_user_reset_n)
        else $error("user reset not asserted after host reset");
    reset_release_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        $rose(o_user_reset_n) |-> $past(i_host_reset_n, 2) && $past(i_host_reset_n))
        else $error("user reset released too early");
    link_follow_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        ##1 o_link_up == $past(i_core_link_up)) else $error("link-up mismatch");
    msi_follow_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        ##1 (o_msi_enable == $past(i_core_msi_enable)
             && o_msi_width == $past(i_core_msi_width)))
        else $error("msi status mismatch");
    parity_off_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        gen_valid && !par_en |-> gen_beat.user == '0)
        else $error("parity sideband driven outside parity mode");
    beat_move_a: assert property (@(posedge i_clk_sys)
        disable iff (i_reset || user_rst)
        gen_valid && !gen_ready |=> gen_valid && $stable(gen_ch))
        else $error("generator beat lost under stall");
    read_data_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !i_reg_read |=> o_reg_rdata == '0)
        else $error("read data outside read answer cycle");

    stall_c: cover property (@(posedge i_clk_sys) disable iff (i_reset)
        o_downstream_payload_valid[0] && !i_downstream_sink_ready[0] ##1
        o_downstream_payload_valid[0] && i_downstream_sink_ready[0]);
    last_c: cover property (@(posedge i_clk_sys) disable iff (i_reset)
        o_downstream_payload_valid[3] && o_downstream_packet_last[3]
        && o_downstream_keep[3] != '1);
    parity_c: cover property (@(posedge i_clk_sys) disable iff (i_reset)
        o_downstream_payload_valid[1] && o_downstream_parity_sideband[1] != '0);
endmodule

// ---- dv/hts_sink.sv ----
// user-logic model that sinks the four host-to-card stream channels
`timescale 1ns/1ns
module hts_sink import hts_pkg::*; (
    input  wire logic                i_clk_sys,
    input  wire logic                i_user_reset_n,
    input  wire logic                i_slow,
    input  wire logic [NCH-1:0]      i_valid,
    input  wire hts_beat_s [NCH-1:0] i_beat,
    output logic      [NCH-1:0]      o_ready
);
    hts_beat_s      got [NCH][$];
    hts_beat_s      held_q [NCH];
    logic [NCH-1:0] wait_q = '0;
    logic [1:0]     cnt_q = 2'h0;
    int             viol = 0;

    // ----------------------------------------------------------------
    // sampling on the user clock, cleared by the user reset
    // ----------------------------------------------------------------
    always @(posedge i_clk_sys) begin
        if (!i_user_reset_n) begin
            o_ready <= '0;
            wait_q  <= '0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            for (int c = 0; c < NCH; c++) begin
                // slow: ready one cycle in four, so the buffer fills and refuses
                o_ready[c] <= !i_slow || (cnt_q == 2'(c));
                if (wait_q[c] && (!i_valid[c] || i_beat[c] !== held_q[c])) begin
                    viol++;
                end
                if (i_valid[c] && o_ready[c]) begin
                    got[c].push_back(i_beat[c]);
                end
                wait_q[c] <= i_valid[c] && !o_ready[c];
                held_q[c] <= i_beat[c];
            end
        end
    end
endmodule

// ---- dv/tb_top.sv ----
// self-checking bench for the host-to-card stream ports
`timescale 1ns/1ns
module tb_top import hts_pkg::*; ;
    logic                       clk, rst, host_n, link, msi_en, wr, rd, slow;
    logic [2:0]                 msi_w;
    logic [ADDR_W-1:0]          addr;
    logic [CSR_W-1:0]           wdata, rdata;
    logic                       uclk, urst_n, o_link, o_msi;
    logic [2:0]                 o_msiw;
    logic [NCH-1:0]             rdy, vld, lst;
    logic [NCH-1:0][DATA_W-1:0] pay;
    logic [NCH-1:0][BYTES-1:0]  kp, par;
    hts_beat_s [NCH-1:0]        beats;
    int                         errors = 0;
    int                         checks = 0;
    int                         cyc = 0;

    hts_top DUT (.i_clk_sys(clk), .i_reset(rst), .i_host_reset_n(host_n),
        .i_core_link_up(link), .i_core_msi_enable(msi_en), .i_core_msi_width(msi_w),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_write(wr), .i_reg_read(rd),
        .o_reg_rdata(rdata), .o_user_clk(uclk), .o_user_reset_n(urst_n),
        .o_link_up(o_link), .o_msi_enable(o_msi), .o_msi_width(o_msiw),
        .i_downstream_sink_ready(rdy), .o_downstream_payload_valid(vld),
        .o_downstream_payload(pay), .o_downstream_keep(kp),
        .o_downstream_packet_last(lst), .o_downstream_parity_sideband(par));

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            beats[c] = '{data: pay[c], keep: kp[c], user: par[c], last: lst[c]};
        end
    end

    hts_sink u_sink (.i_clk_sys(uclk), .i_user_reset_n(urst_n), .i_slow(slow),
        .i_valid(vld), .i_beat(beats), .o_ready(rdy));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // access and compare tasks
    // ----------------------------------------------------------------
    task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [CSR_W-1:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a,
                          input logic [CSR_W-1:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 cmp(what, exp, rdata);
    endtask

    task automatic send(input int len, input int ch, input bit eop);
        reg_wr(OFS_DESC, (32'(eop) << 18) | (32'(ch) << 16) | 32'(len));
    endtask

    task automatic chk_desc(input int len, input int ch, input bit eop,
                            input logic [7:0] seed, input bit pm);
        int          nb;
        int          n;
        logic [63:0] d, dm;
        logic [7:0]  k, u, by;
        hts_beat_s   b;
        nb = (len + 7) / 8;
        n = 0;
        while (u_sink.got[ch].size() < nb && n < 400) begin
            @(posedge clk);
            n++;
        end
        cmp("beat count", nb, u_sink.got[ch].size());
        for (int j = 0; j < nb && u_sink.got[ch].size() > 0; j++) begin
            b = u_sink.got[ch].pop_front();
            d = '0;
            dm = '0;
            k = '0;
            u = '0;
            for (int i = 0; i < 8; i++) begin
                if (j * 8 + i < len) begin
                    by = seed + 8'(j * 8 + i);
                    d[i*8+:8] = by;
                    dm[i*8+:8] = 8'hFF;
                    k[i] = 1'b1;
                    u[i] = pm & ^by;
                end
            end
            cmp("payload", d, b.data & dm);
            cmp("keep", k, b.keep);
            cmp("sideband", u, b.user & k);
            cmp("last", eop && j == nb - 1, b.last);
        end
        repeat (4) @(posedge clk);
        cmp("extra beats", 0, u_sink.got[ch].size());
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            errors++;
            stop_test();
        end
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        {rst, host_n, link, msi_en, wr, rd, slow} = 7'b1100000;
        msi_w = 3'h0;
        addr = '0;
        wdata = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk("ctrl reset", OFS_CTRL, 32'h0000000F);
        rd_chk("seed reset", OFS_SEED, 32'h00000000);
        rd_chk("unmapped", 8'h14, 32'h00000000);
        reg_wr(8'h14, 32'hFFFFFFFF);
        reg_wr(OFS_SEED, 32'hFFFFFFFF);
        rd_chk("seed width", OFS_SEED, 32'h000000FF);
        @(posedge clk);
        link <= 1'b1;
        msi_en <= 1'b1;
        msi_w <= 3'h5;
        repeat (2) @(posedge clk);
        #1 cmp("link up", 1, o_link);
        cmp("msi enable", 1, o_msi);
        cmp("msi width", 5, o_msiw);
        cmp("user clock", clk, uclk);
        rd_chk("status", OFS_STAT, 32'h00000017);
        $display("test 1 done");
        reg_wr(OFS_SEED, 32'h0);
        reg_wr(OFS_DONE, 32'h0);
        send(10, 0, 1);
        chk_desc(10, 0, 1, 8'h00, 0);
        rd_chk("done count", OFS_DONE, 32'h1);
        send(3, 1, 0);
        chk_desc(3, 1, 0, 8'h00, 0);
        send(5, 1, 1);
        chk_desc(5, 1, 1, 8'h00, 0);
        $display("test 2 done");
        reg_wr(OFS_CTRL, 32'h1F);
        reg_wr(OFS_SEED, 32'hF8);
        slow <= 1'b1;
        reg_wr(OFS_DONE, 32'h0);
        for (int c = 0; c < NCH; c++) begin
            send(17 + c, c, c[0]);
            chk_desc(17 + c, c, c[0], 8'hF8, 1);
        end
        rd_chk("done count", OFS_DONE, 32'h4);
        $display("test 3 done");
        reg_wr(OFS_CTRL, 32'h17);
        send(8, 3, 1);
        repeat (20) @(posedge clk);
        #1 cmp("disabled valid", 0, vld[3]);
        rd_chk("busy stall", OFS_STAT, 32'h00000037);
        reg_wr(OFS_CTRL, 32'h1F);
        chk_desc(8, 3, 1, 8'hF8, 1);
        $display("test 4 done");
        @(posedge clk);
        host_n <= 1'b0;
        @(posedge clk);
        #1 cmp("user reset low", 0, urst_n);
        @(posedge clk);
        host_n <= 1'b1;
        @(posedge clk);
        #1 cmp("user reset held", 0, urst_n);
        repeat (2) @(posedge clk);
        #1 cmp("user reset high", 1, urst_n);
        cmp("valid flushed", 0, vld);
        reg_wr(OFS_SEED, 32'h10);
        send(9, 2, 1);
        chk_desc(9, 2, 1, 8'h10, 1);
        cmp("valid held", 0, u_sink.viol);
        $display("test 5 done");
        stop_test();
    end
endmodule
